// file: shared/pioscn_consts.svh
// constants for the i/o channel scanner
`ifndef PIOSCN_CONSTS_SVH
`define PIOSCN_CONSTS_SVH

`define PIOSCN_CLK_MHZ 125
`define PIOSCN_PAIR_SCAN_MS 7
`define PIOSCN_PAIR_SCAN_CYC (`PIOSCN_PAIR_SCAN_MS * `PIOSCN_CLK_MHZ * 1000)
`define PIOSCN_TENTH_MS 100
`define PIOSCN_TENTH_CYC (`PIOSCN_TENTH_MS * `PIOSCN_CLK_MHZ * 1000)
`define PIOSCN_USABLE_PTS 1000
`define PIOSCN_CHAN_PTS 1024
`define PIOSCN_WORDS_PER_CHAN 64
`define PIOSCN_INT_BASE 10'h3e8
`define PIOSCN_STAT_BASE 10'h3f8
`define PIOSCN_SP10_NONE 8'h80
`define PIOSCN_AUX_OUT_FIRST 13'h0001
`define PIOSCN_AUX_OUT_LAST 13'h0040
`define PIOSCN_AUX_IN_FIRST 13'h0041
`define PIOSCN_AUX_IN_LAST 13'h0080
`define PIOSCN_EXP_BASE 13'h0081
`define PIOSCN_EXP_AUX_BASE 13'h0481
// apb register byte offsets
`define PIOSCN_REG_CTRL 12'h000
`define PIOSCN_REG_STAT 12'h004
`define PIOSCN_REG_SP10 12'h008
`define PIOSCN_REG_TIME0 12'h00c
`define PIOSCN_REG_TIME1 12'h010
`define PIOSCN_REG_TIME2 12'h014
`define PIOSCN_REG_IMG_ADDR 12'h018
`define PIOSCN_REG_IMG_DATA 12'h01c
`define PIOSCN_REG_INTR 12'h020
`define PIOSCN_REG_TSTAT 12'h024
`define PIOSCN_CTRL_RESET 32'h0000_0001

`endif

// file: shared/pioscn_pkg.sv
// types for the i/o channel scanner
package pioscn_pkg;
  typedef enum logic {PIOSCN_NORMAL, PIOSCN_EXPANDED} pioscn_mode_t;
  typedef struct packed {
    logic [2:0] chan;     // channel code toward transmitters
    logic scan_active;    // pair scan under way
    logic strobe_status;  // status byte request
  } pioscn_chain_cmd_t;
  typedef struct packed {
    logic status_valid;   // transmitter answered
    logic [7:0] status;   // status byte
    logic parity_err;     // parity error during this scan
  } pioscn_chain_rsp_t;
endpackage : pioscn_pkg

// file: verilog/pioscn_time_ref.sv
// time reference: days, hours, minutes, seconds, tenths
`timescale 1ns/10ps
`include "pioscn_consts.svh"
module pioscn_time_ref #(
  parameter int TENTH_CYC = `PIOSCN_TENTH_CYC
) (
  input wire logic i_clk,            // system clock
  input wire logic i_reset_n,        // async reset, active low
  output logic [15:0] o_days,        // day count
  output logic [15:0] o_hour_min,    // hours high byte, minutes low byte
  output logic [15:0] o_sec_tenth    // seconds high byte, tenths low byte
);
  logic [31:0] div_q;
  logic [7:0] hr_q, mn_q, sc_q, tn_q;
  logic [15:0] day_q;
  logic tick;

  assign tick = (div_q == 32'(TENTH_CYC - 1));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 32'h0;
    end else if (tick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tn_q <= 8'h0;
      sc_q <= 8'h0;
      mn_q <= 8'h0;
      hr_q <= 8'h0;
      day_q <= 16'h0;
    end else if (tick) begin
      if (tn_q != 8'h9) begin
        tn_q <= tn_q + 8'h1;
      end else begin
        tn_q <= 8'h0;
        if (sc_q != 8'h3b) begin
          sc_q <= sc_q + 8'h1;
        end else begin
          sc_q <= 8'h0;
          if (mn_q != 8'h3b) begin
            mn_q <= mn_q + 8'h1;
          end else begin
            mn_q <= 8'h0;
            if (hr_q != 8'h17) begin
              hr_q <= hr_q + 8'h1;
            end else begin
              hr_q <= 8'h0;
              day_q <= day_q + 16'h1;
            end
          end
        end
      end
    end
  end

  assign o_days = day_q;
  assign o_hour_min = {hr_q, mn_q};
  assign o_sec_tenth = {sc_q, tn_q};
endmodule : pioscn_time_ref

// file: verilog/pioscn_scanner.sv
// i/o channel scanner with apb register access
`timescale 1ns/10ps
`include "pioscn_consts.svh"
module pioscn_scanner #(
  parameter int PAIR_SCAN_CYC = `PIOSCN_PAIR_SCAN_CYC,
  parameter int TENTH_CYC = `PIOSCN_TENTH_CYC
) (
  input wire logic i_clk,                              // 125 mhz clock
  input wire logic i_reset_n,                          // async reset, active low
  input wire logic i_psel,                             // apb select
  input wire logic i_penable,                          // apb enable
  input wire logic i_pwrite,                           // apb write
  input wire logic [11:0] i_paddr,                     // apb byte address
  input wire logic [31:0] i_pwdata,                    // apb write data
  output logic [31:0] o_prdata,                        // apb read data
  output logic o_pready,                               // apb ready
  output logic o_pslverr,                              // apb error
  input wire pioscn_pkg::pioscn_chain_rsp_t i_main_rsp, // main chain answer
  input wire pioscn_pkg::pioscn_chain_rsp_t i_aux_rsp,  // aux chain answer
  input wire logic [7:0] i_main_intr,                  // main chain interrupt inputs
  input wire logic [7:0] i_aux_intr,                   // aux chain interrupt inputs
  output pioscn_pkg::pioscn_chain_cmd_t o_main_cmd,    // main chain command
  output pioscn_pkg::pioscn_chain_cmd_t o_aux_cmd,     // aux chain command
  output logic o_scan_done                             // one-cycle pulse per full scan
);
  // eight channels a chain; aux tables from channel 8
  localparam int IMG_WORDS = 16 * `PIOSCN_WORDS_PER_CHAN;

  typedef enum logic [1:0] {PIOSCN_IDLE, PIOSCN_SEL, PIOSCN_SCAN, PIOSCN_NEXT} pioscn_state_t;

  // input image: 16 channels x 64 words of 16 bits
  logic [15:0] img_q [IMG_WORDS];
  pioscn_state_t state_q;
  logic run_q;
  pioscn_pkg::pioscn_mode_t mode_q;
  logic [7:0] pair_en_q;
  logic [2:0] pair_q;
  logic [31:0] cnt_q;
  logic [7:0] sp10_q;
  logic sp10_set_q;
  logic [9:0] img_addr_q;
  logic [7:0] m_int_s1, m_int_s2, m_int_s3, a_int_s1, a_int_s2, a_int_s3;
  logic [7:0] m_int_q, a_int_q;
  logic [7:0] m_tstat_q, a_tstat_q;
  logic [15:0] t_days, t_hm, t_st;
  logic [31:0] rdata_d;
  logic wr_en, rd_ok;
  logic [3:0] m_chan, a_chan;
  logic has_next;
  logic [2:0] next_pair;
  logic [31:0] fault_stamp_q;
  logic [3:0] first_pair;
  logic wr_ctrl, wr_img_addr, wr_img_data, wr_sp10;
  logic parity_hit;

  // first enabled pair at or above start, in ascending order
  function automatic logic [3:0] pioscn_find(input logic [7:0] en, input logic [2:0] start);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (3'(i) >= start)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : pioscn_find

  // word index of a status bit: channel base plus point within channel
  function automatic logic [9:0] pioscn_word(input logic [3:0] chan, input logic [9:0] pt);
    return {chan, pt[9:4]};
  endfunction : pioscn_word

  pioscn_time_ref #(
    .TENTH_CYC(TENTH_CYC)
  ) u_time (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_days(t_days),
    .o_hour_min(t_hm),
    .o_sec_tenth(t_st)
  );

  assign wr_en = i_psel && i_penable && i_pwrite;

  // one strobe a writable register (ctrl, image address, image data, sp10), all in the access cycle
  assign wr_ctrl = wr_en && (i_paddr == `PIOSCN_REG_CTRL);
  assign wr_img_addr = wr_en && (i_paddr == `PIOSCN_REG_IMG_ADDR);
  assign wr_img_data = wr_en && (i_paddr == `PIOSCN_REG_IMG_DATA);
  assign wr_sp10 = wr_en && (i_paddr == `PIOSCN_REG_SP10);

  // channel code pairs main n with aux n+8
  assign m_chan = {1'b0, pair_q};
  assign a_chan = {1'b1, pair_q};

  // skip disabled pairs; in normal mode only pair 0 exists
  always_comb begin
    logic [3:0] f;
    f = 4'h8;
    if (mode_q == pioscn_pkg::PIOSCN_EXPANDED) begin
      f = pioscn_find(pair_en_q, pair_q + 3'h1);
      // pair 7 ends the scan; the search must not wrap into this scan
      if (pair_q == 3'h7) begin
        f = 4'h8;
      end
    end
    has_next = !f[3];
    next_pair = f[2:0];
  end

  // normal mode scans pair 0 only
  always_comb begin
    first_pair = 4'h0;
    if (mode_q == pioscn_pkg::PIOSCN_EXPANDED) begin
      first_pair = pioscn_find(pair_en_q, 3'h0);
    end
  end

  // scan configuration; a change in mid-scan steers only pairs not yet begun
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q <= 1'b0;
      mode_q <= pioscn_pkg::PIOSCN_NORMAL;
      pair_en_q <= 8'h01;
    end else if (wr_ctrl) begin
      run_q <= i_pwdata[0];
      mode_q <= pioscn_pkg::pioscn_mode_t'(i_pwdata[1]);
      pair_en_q <= i_pwdata[15:8];
    end
  end

  // image pointer for software access
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      img_addr_q <= 10'h0;
    end else if (wr_img_addr) begin
      img_addr_q <= i_pwdata[9:0];
    end
  end

  // select code first, then scan, lowest enabled pair upward
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= PIOSCN_IDLE;
      pair_q <= 3'h0;
      cnt_q <= 32'h0;
      o_scan_done <= 1'b0;
    end else begin
      o_scan_done <= 1'b0;
      case (state_q)
        PIOSCN_IDLE: begin
          // no enabled pair in expanded mode: stay idle, no done pulse
          if (run_q && !first_pair[3]) begin
            pair_q <= first_pair[2:0];
            state_q <= PIOSCN_SEL;
          end
        end
        PIOSCN_SEL: begin
          cnt_q <= 32'h0;
          state_q <= PIOSCN_SCAN;
        end
        PIOSCN_SCAN: begin
          // seven ms per pair
          // cnt_q runs from 0 to PAIR_SCAN_CYC-1, so the pair lasts PAIR_SCAN_CYC cycles
          if (cnt_q == 32'(PAIR_SCAN_CYC - 1)) begin
            state_q <= PIOSCN_NEXT;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        PIOSCN_NEXT: begin
          // code changes only here and on leaving idle, between pair scans
          if (has_next) begin
            pair_q <= next_pair;
            state_q <= PIOSCN_SEL;
          end else begin
            o_scan_done <= 1'b1;
            state_q <= PIOSCN_IDLE;
          end
        end
        default: begin
          state_q <= PIOSCN_IDLE;
        end
      endcase
    end
  end

  // both chains driven by the same pair scan
  // code and strobe leave together, one cycle behind the state machine
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_main_cmd <= '0;
      o_aux_cmd <= '0;
    end else begin
      o_main_cmd.chan <= pair_q;
      o_aux_cmd.chan <= pair_q;
      o_main_cmd.scan_active <= (state_q == PIOSCN_SCAN);
      o_aux_cmd.scan_active <= (state_q == PIOSCN_SCAN);
      o_main_cmd.strobe_status <= (state_q == PIOSCN_SEL);
      o_aux_cmd.strobe_status <= (state_q == PIOSCN_SEL);
    end
  end

  // interrupt lines pass at all times; three-stage sync
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m_int_s1 <= 8'h0;
      m_int_s2 <= 8'h0;
      m_int_s3 <= 8'h0;
      m_int_q <= 8'h0;
    end else begin
      m_int_s1 <= i_main_intr;
      m_int_s2 <= m_int_s1;
      m_int_s3 <= m_int_s2;
      // a level counts only once two stages agree, so a glitch is dropped
      for (int i = 0; i < 8; i++) begin
        if (m_int_s2[i] == m_int_s3[i]) begin
          m_int_q[i] <= m_int_s3[i];
        end
      end
    end
  end

  // aux chain interrupt lines, same filter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_int_s1 <= 8'h0;
      a_int_s2 <= 8'h0;
      a_int_s3 <= 8'h0;
      a_int_q <= 8'h0;
    end else begin
      a_int_s1 <= i_aux_intr;
      a_int_s2 <= a_int_s1;
      a_int_s3 <= a_int_s2;
      for (int i = 0; i < 8; i++) begin
        if (a_int_s2[i] == a_int_s3[i]) begin
          a_int_q[i] <= a_int_s3[i];
        end
      end
    end
  end

  // image words; reserved points 1001..1024 hold status and interrupts
  // no reset on the image: software fills any word it reads back
  always_ff @(posedge i_clk) begin
    // interrupt data at points 1001..1008 of channel 0 and 8
    img_q[pioscn_word(4'h0, `PIOSCN_INT_BASE)][15:8] <= m_int_q;
    img_q[pioscn_word(4'h8, `PIOSCN_INT_BASE)][15:8] <= a_int_q;
    if (state_q == PIOSCN_SCAN) begin
      // status byte at points 1017..1024; only when answered
      if (i_main_rsp.status_valid) begin
        img_q[pioscn_word(m_chan, `PIOSCN_STAT_BASE)][15:8] <= i_main_rsp.status;
      end
      if (i_aux_rsp.status_valid) begin
        img_q[pioscn_word(a_chan, `PIOSCN_STAT_BASE)][15:8] <= i_aux_rsp.status;
      end
    end
    if (wr_img_data) begin
      img_q[img_addr_q] <= i_pwdata[15:0];
    end
  end

  // last status bytes seen, for quick software reads
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m_tstat_q <= 8'h0;
      a_tstat_q <= 8'h0;
    end else if (state_q == PIOSCN_SCAN) begin
      if (i_main_rsp.status_valid) begin
        m_tstat_q <= i_main_rsp.status;
      end
      if (i_aux_rsp.status_valid) begin
        a_tstat_q <= i_aux_rsp.status;
      end
    end
  end

  assign parity_hit = (state_q == PIOSCN_SCAN)
    && (i_main_rsp.parity_err || i_aux_rsp.parity_err);

  // parity channel record; set wins over a software clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sp10_q <= 8'h0;
      sp10_set_q <= 1'b0;
    end else if (parity_hit) begin
      sp10_set_q <= 1'b1;
      if (mode_q == pioscn_pkg::PIOSCN_NORMAL || pair_q == 3'h0) begin
        sp10_q <= `PIOSCN_SP10_NONE;
      end else if (i_main_rsp.parity_err) begin
        sp10_q <= {4'h0, m_chan};
      end else begin
        sp10_q <= {4'h0, a_chan};
      end
    end else if (wr_sp10) begin
      sp10_set_q <= 1'b0;
      sp10_q <= 8'h0;
    end
  end

  // stamp the fault with the time reference
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_stamp_q <= 32'h0;
    end else if (parity_hit) begin
      fault_stamp_q <= {t_hm, t_st};
    end
  end

  // apb read mux; unmapped reads return zero with slverr
  // reads have no side effects, so software may repeat them freely
  always_comb begin
    rdata_d = 32'h0;
    rd_ok = 1'b1;
    case (i_paddr)
      `PIOSCN_REG_CTRL: rdata_d = {16'h0, pair_en_q, 6'h0, mode_q, run_q};
      `PIOSCN_REG_STAT: rdata_d = {24'h0, state_q == PIOSCN_SCAN, pair_q, 2'h0, state_q};
      `PIOSCN_REG_SP10: rdata_d = {23'h0, sp10_set_q, sp10_q};
      `PIOSCN_REG_TIME0: rdata_d = {16'h0, t_days};
      `PIOSCN_REG_TIME1: rdata_d = {16'h0, t_hm};
      `PIOSCN_REG_TIME2: rdata_d = {16'h0, t_st};
      `PIOSCN_REG_IMG_ADDR: rdata_d = {22'h0, img_addr_q};
      `PIOSCN_REG_IMG_DATA: rdata_d = {16'h0, img_q[img_addr_q]};
      `PIOSCN_REG_INTR: rdata_d = {fault_stamp_q[31:16], a_int_q, m_int_q};
      `PIOSCN_REG_TSTAT: rdata_d = {16'h0, a_tstat_q, m_tstat_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // no wait state: ready rises in the first access cycle
  // the answer is latched in the setup cycle, so an access never waits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0 : rdata_d;
      o_pslverr <= !rd_ok;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end
endmodule : pioscn_scanner

// file: tb/pioscn_assertions.sv
// port checks for the channel scanner
`timescale 1ns/10ps
module pioscn_assertions #(
  parameter int PAIR_SCAN_CYC = 20
) (
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // reset
  input wire logic i_psel, // apb
  input wire logic i_penable, // apb
  input wire logic i_pwrite, // apb
  input wire logic [11:0] i_paddr, // apb
  input wire logic [31:0] i_pwdata, // apb
  input wire logic [31:0] o_prdata, // apb
  input wire logic o_pready, // apb
  input wire logic o_pslverr, // apb
  input wire pioscn_pkg::pioscn_chain_rsp_t i_main_rsp, // main answer
  input wire pioscn_pkg::pioscn_chain_rsp_t i_aux_rsp, // aux answer
  input wire logic [7:0] i_main_intr, // main intr
  input wire logic [7:0] i_aux_intr, // aux intr
  input wire pioscn_pkg::pioscn_chain_cmd_t o_main_cmd, // main cmd
  input wire pioscn_pkg::pioscn_chain_cmd_t o_aux_cmd, // aux cmd
  input wire logic o_scan_done // scan end
);
  int run_q;
  // length of the current run of scan cycles
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q <= 0;
    end else begin
      run_q <= o_main_cmd.scan_active ? run_q + 1 : 0;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ready_next_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready not in first access cycle");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  err_refuse_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("refused access not clean");
  done_pulse_a: assert property (o_scan_done |=> !o_scan_done)
    else $error("scan done held");
  pair_step_a: assert property (
    o_main_cmd.chan == o_aux_cmd.chan && o_main_cmd.scan_active == o_aux_cmd.scan_active)
    else $error("chains out of step");
  code_hold_a: assert property (
    o_main_cmd.scan_active && $past(o_main_cmd.scan_active) |-> $stable(o_main_cmd.chan))
    else $error("channel code moved in pair scan");
  code_first_a: assert property (
    o_main_cmd.strobe_status |=> o_main_cmd.scan_active && $stable(o_main_cmd.chan))
    else $error("scan not after channel code");
  pair_time_a: assert property (
    $fell(o_main_cmd.scan_active) |-> run_q == PAIR_SCAN_CYC)
    else $error("pair scan length wrong");
  pair_cap_a: assert property (run_q <= PAIR_SCAN_CYC)
    else $error("pair scan overrun");
endmodule : pioscn_assertions

bind pioscn_scanner pioscn_assertions #(.PAIR_SCAN_CYC(PAIR_SCAN_CYC)) chk_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_main_rsp(i_main_rsp),
  .i_aux_rsp(i_aux_rsp), .i_main_intr(i_main_intr), .i_aux_intr(i_aux_intr),
  .o_main_cmd(o_main_cmd), .o_aux_cmd(o_aux_cmd), .o_scan_done(o_scan_done)
);

// file: tb/pioscn_xmtr_model.sv
// far-side model: decoding transmitters and modules on both chains
`timescale 1ns/10ps
module pioscn_xmtr_model (
  input wire pioscn_pkg::pioscn_chain_cmd_t i_main_cmd, // main cmd
  input wire pioscn_pkg::pioscn_chain_cmd_t i_aux_cmd, // aux cmd
  input wire logic [15:0] i_answer_en, // answering channels
  input wire logic i_perr_on, // inject parity fault
  input wire logic [3:0] i_perr_chan, // faulty channel
  input wire logic [7:0] i_main_src, // main intr module
  input wire logic [7:0] i_aux_src, // aux intr module
  output pioscn_pkg::pioscn_chain_rsp_t o_main_rsp, // main answer
  output pioscn_pkg::pioscn_chain_rsp_t o_aux_rsp, // aux answer
  output logic [7:0] o_main_intr, // main intr
  output logic [7:0] o_aux_intr // aux intr
);
  logic [7:0] main_byte;
  logic [7:0] aux_byte;
  assign main_byte = {1'h0, 1'h1, 2'h0, 1'h1, i_main_cmd.chan};
  assign aux_byte = {1'h1, 1'h1, 2'h0, 1'h1, i_aux_cmd.chan};
  // one decoder per channel; silent lines show the inverse
  assign o_main_rsp.status_valid = i_main_cmd.scan_active & i_answer_en[{1'h0, i_main_cmd.chan}];
  assign o_aux_rsp.status_valid = i_aux_cmd.scan_active & i_answer_en[{1'h1, i_aux_cmd.chan}];
  assign o_main_rsp.status = o_main_rsp.status_valid ? main_byte : ~main_byte;
  assign o_aux_rsp.status = o_aux_rsp.status_valid ? aux_byte : ~aux_byte;
  assign o_main_rsp.parity_err = i_main_cmd.scan_active & i_perr_on
    & (i_perr_chan == {1'h0, i_main_cmd.chan});
  assign o_aux_rsp.parity_err = i_aux_cmd.scan_active & i_perr_on
    & (i_perr_chan == {1'h1, i_aux_cmd.chan});
  assign o_main_intr = i_main_src;
  assign o_aux_intr = i_aux_src;
endmodule : pioscn_xmtr_model

// file: tb/pioscn_scanner_test.sv
// self-checking bench for the channel scanner
`timescale 1ns/10ps
`include "pioscn_consts.svh"
module pioscn_scanner_test;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, done;
  logic [15:0] ans_en = 16'h0;
  logic perr_on = 1'h0;
  logic [3:0] perr_chan = 4'h0;
  logic [7:0] src_m = 8'h0;
  logic [7:0] src_a = 8'h0;
  logic [7:0] intr_m, intr_a;
  pioscn_pkg::pioscn_chain_rsp_t rsp_m, rsp_a;
  pioscn_pkg::pioscn_chain_cmd_t cmd_m, cmd_a;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [2:0] seen[$];
  // short counts keep the run small
  pioscn_scanner #(.PAIR_SCAN_CYC(20), .TENTH_CYC(10)) uut (.i_clk(clk), .i_reset_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_main_rsp(rsp_m),
    .i_aux_rsp(rsp_a), .i_main_intr(intr_m), .i_aux_intr(intr_a), .o_main_cmd(cmd_m),
    .o_aux_cmd(cmd_a), .o_scan_done(done));
  pioscn_xmtr_model xm (.i_main_cmd(cmd_m), .i_aux_cmd(cmd_a), .i_answer_en(ans_en),
    .i_perr_on(perr_on), .i_perr_chan(perr_chan), .i_main_src(src_m), .i_aux_src(src_a),
    .o_main_rsp(rsp_m), .o_aux_rsp(rsp_a), .o_main_intr(intr_m), .o_aux_intr(intr_a));
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cmd_m.strobe_status === 1'h1) seen.push_back(cmd_m.chan);
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task img_rd(input logic [31:0] ch, input logic [31:0] w);
    apb(1'h1, `PIOSCN_REG_IMG_ADDR, ch * 32'h40 + w);
    apb(1'h0, `PIOSCN_REG_IMG_DATA, 32'h0);
  endtask : img_rd
  task wait_done(input int k);
    repeat (k) begin
      @(posedge clk);
      while (done !== 1'h1) @(posedge clk);
    end
  endtask : wait_done
  // order may wrap from the highest enabled pair back to the lowest
  task chk_seen(input logic [7:0] en, input logic [2:0] lo, input logic [2:0] hi);
    logic [7:0] m;
    int bad;
    m = 8'h0;
    bad = 0;
    foreach (seen[i]) begin
      m[seen[i]] = 1'h1;
      if (i > 0 && seen[i] <= seen[i-1] && !(seen[i] == lo && seen[i-1] == hi)) bad++;
    end
    chk("pairs scanned", {24'h0, en}, {24'h0, m});
    chk("pair order", 32'h0, 32'(bad));
  endtask : chk_seen
  task t_reset;
    apb(1'h0, `PIOSCN_REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0100, rd);
    apb(1'h0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_reset
  task t_time;
    logic [31:0] t0;
    apb(1'h0, `PIOSCN_REG_TIME2, 32'h0);
    t0 = rd;
    repeat (37) @(posedge clk);
    apb(1'h0, `PIOSCN_REG_TIME2, 32'h0);
    chk("tenths step", 32'h4, (rd[15:8] * 10 + rd[7:0]) - (t0[15:8] * 10 + t0[7:0]));
  endtask : t_time
  task t_scan(input logic [31:0] c, input logic [7:0] en, input logic [2:0] lo, hi);
    apb(1'h1, `PIOSCN_REG_CTRL, c);
    wait_done(1);
    seen.delete();
    wait_done(2);
    chk_seen(en, lo, hi);
  endtask : t_scan
  task t_status;
    apb(1'h1, `PIOSCN_REG_CTRL, 32'h0000_0402);
    ans_en <= 16'h0004;
    img_rd(32'ha, 32'h3f);
    apb(1'h1, `PIOSCN_REG_IMG_DATA, 32'h1234);
    t_scan(32'h0000_0403, 8'h04, 3'h2, 3'h2);
    img_rd(32'h2, 32'h3f);
    chk("status byte", 32'h4a00, rd & 32'hff00);
    img_rd(32'ha, 32'h3f);
    chk("silent kept", 32'h1234, rd & 32'hffff);
    apb(1'h0, `PIOSCN_REG_TSTAT, 32'h0);
    chk("last status", 32'h4a, rd & 32'hff);
  endtask : t_status
  task t_perr(input logic [3:0] ch, input logic [31:0] c, input logic [31:0] e);
    perr_chan <= ch;
    perr_on <= 1'h1;
    apb(1'h1, `PIOSCN_REG_CTRL, c);
    wait_done(1);
    apb(1'h1, `PIOSCN_REG_SP10, 32'h0);
    wait_done(2);
    apb(1'h0, `PIOSCN_REG_SP10, 32'h0);
    chk("scratch ten", e, rd & 32'h1ff);
  endtask : t_perr
  task t_intr;
    perr_on <= 1'h0;
    src_m <= 8'ha5;
    src_a <= 8'h3c;
    apb(1'h1, `PIOSCN_REG_CTRL, 32'h0000_0203);
    wait_done(2);
    apb(1'h0, `PIOSCN_REG_INTR, 32'h0);
    chk("intr reg", 32'h3ca5, rd & 32'hffff);
    img_rd(32'h0, 32'h3e);
    chk("intr main", 32'ha500, rd & 32'hff00);
    img_rd(32'h8, 32'h3e);
    chk("intr aux", 32'h3c00, rd & 32'hff00);
  endtask : t_intr
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_time();
    t_scan(32'h0000_ff01, 8'h01, 3'h0, 3'h0);
    t_scan(32'h0000_a503, 8'ha5, 3'h0, 3'h7);
    t_scan(32'h0000_8003, 8'h80, 3'h7, 3'h7);
    t_status();
    t_perr(4'hb, 32'h0000_0903, 32'h10b);
    t_perr(4'h8, 32'h0000_0903, 32'h180);
    t_perr(4'h0, 32'h0000_0901, 32'h180);
    t_intr();
    complete_run();
  end
endmodule : pioscn_scanner_test
